//--- hw/txf_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 125 MHz register clock
// Notes: Byte address of a register is four times its index
`ifndef TXF_CONSTS_SVH
`define TXF_CONSTS_SVH
`define TXF_IDX_PRIMARY 8'h09
`define TXF_IDX_ALT 8'h0d
`define TXF_IDX_SECOND 8'h11
`define TXF_IDX_CTRL 8'h20
`define TXF_IDX_STAT 8'h21
`define TXF_ADDR_PRIMARY 8'(`TXF_IDX_PRIMARY * 4)
`define TXF_ADDR_ALT 8'(`TXF_IDX_ALT * 4)
`define TXF_ADDR_SECOND 8'(`TXF_IDX_SECOND * 4)
`define TXF_ADDR_CTRL 8'(`TXF_IDX_CTRL * 4)
`define TXF_ADDR_STAT 8'(`TXF_IDX_STAT * 4)
`define TXF_SEL_MSB 3
`define TXF_SEL_LSB 0
`define TXF_SEL_RESET 4'h0
`define TXF_AC_DEFAULT 4'h7
`define TXF_RATE_SUPPORT 16'h7fff
`define TXF_CTRL_MODE_MSB 1
`define TXF_CTRL_MODE_LSB 0
`define TXF_CTRL_GEN1 2
`define TXF_STAT_HOLD 4
`define TXF_STAT_BUSY 5
`define TXF_STAT_AC 6
`define TXF_RESP_OKAY 2'h0
`define TXF_RESP_SLVERR 2'h2
`define TXF_CLK_PERIOD_NS 8
`define TXF_HOLD_TIME_NS 2000
`define TXF_HOLD_CYCLES ((`TXF_HOLD_TIME_NS + `TXF_CLK_PERIOD_NS - 1) / `TXF_CLK_PERIOD_NS)
`endif

//--- hw/txf_pkg.sv
// Purpose: Types of the transmit clock rate select block
// Assumes: Constants come from txf_consts.svh
// Notes: Mode code 3 behaves like asynchronous
package txf_pkg;
    typedef enum logic [1:0] {TXF_SYNC, TXF_PSEUDO, TXF_ASYNC, TXF_MODE_RSV} txf_mode_e;

    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [3:0] sel;
        txf_mode_e mode;
        logic gen1;
        logic [3:0] in_use;
        logic strap_done;
        logic ac_s1;
        logic ac_s2;
        logic rst_s1;
        logic rst_s2;
        logic stop_s1;
        logic stop_s2;
        logic up_prev;
        logic holding;
        logic [8:0] hold_cnt;
        logic [5:0] xfer_word;
        logic req_tgl;
        logic ack_s1;
        logic ack_s2;
    } txf_core_s;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_tgl;
        logic [5:0] word;
        logic [11:0] mhz;
    } txf_link_s;
endpackage : txf_pkg

//--- hw/txf_rate_select.sv
// Purpose: Software rate select for the link transmit clock, applied at link re-initialisation
// Assumes: AXI4-Lite register port on CLOCK; LINK_CLOCK drives the link side
// Notes: Copy at the alternate offset aliases the primary; second link copy is reserved
`include "txf_consts.svh"

// Operation
// - Four-bit read/write rate select, bits 3:0, zero after cold reset.
// - Select sets transmit clock; data rate is twice that clock.
// - Code table 200..2600 MHz; code 15 vendor specific.
// - Single-link device treats the second link copy as reserved.
// - Written value waits for link reset or stop disconnect to apply.
// - Host block applies on the link reset, never system reset.
// - Secondary block applies on the secondary chain link reset.
// - Asynchronous and pseudo-synchronous modes treat the rate as a maximum.
// - Synchronous mode runs receiver and transmitter at the programmed rate.
// - 200 MHz synchronous must work; other codes optional.
// - First-generation: hold rate 2 us after seeing link reset asserted.
// - AC-coupled links default to 1.2 GHz.
module txf_rate_select
    import txf_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic LINK_CLOCK,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic LINK_RESET_N,
    input wire logic LINK_STOP_DISCONNECT_N,
    input wire logic AC_COUPLED,
    output logic [3:0] TX_RATE_CODE,
    output logic [11:0] TX_CLOCK_MHZ,
    output logic [12:0] DATA_RATE_MHZ,
    output logic RATE_IS_LIMIT,
    output logic RX_AT_TX_RATE,
    output logic VENDOR_RATE
);
    localparam logic [15:0] RATE_SUPPORT = `TXF_RATE_SUPPORT;
    localparam logic [8:0] HOLD_LAST = 9'(`TXF_HOLD_CYCLES - 1);

    txf_core_s core_ff;
    txf_core_s nxt_core;
    txf_link_s link_ff;
    txf_link_s nxt_link;
    logic link_up;
    logic up_fall;
    logic apply;
    logic [3:0] apply_code;
    logic aw_ready;
    logic w_ready;
    logic ar_ready;

    function automatic logic [11:0] txf_mhz(input logic [3:0] code);
        logic [11:0] r;
        r = 12'h000;
        case (code)
            4'h0: r = 12'h0c8;
            4'h1: r = 12'h12c;
            4'h2: r = 12'h190;
            4'h3: r = 12'h1f4;
            4'h4: r = 12'h258;
            4'h5: r = 12'h320;
            4'h6: r = 12'h3e8;
            4'hf: r = 12'h000;
            default: r = 12'h4b0 + 12'h0c8 * 12'({8'h00, code - 4'h7});
        endcase
        return r;
    endfunction : txf_mhz

    function automatic logic [7:0] txf_read(input txf_core_s s, input logic [7:0] addr);
        logic [7:0] r;
        r = 8'h00;
        if (addr == `TXF_ADDR_PRIMARY || addr == `TXF_ADDR_ALT)
        begin
            r[`TXF_SEL_MSB:`TXF_SEL_LSB] = s.sel;
        end
        else if (addr == `TXF_ADDR_CTRL)
        begin
            r[`TXF_CTRL_MODE_MSB:`TXF_CTRL_MODE_LSB] = s.mode;
            r[`TXF_CTRL_GEN1] = s.gen1;
        end
        else if (addr == `TXF_ADDR_STAT)
        begin
            r[3:0] = s.in_use;
            r[`TXF_STAT_HOLD] = s.holding;
            r[`TXF_STAT_BUSY] = s.ack_s2 != s.req_tgl;
            r[`TXF_STAT_AC] = s.ac_s2;
        end
        return r;
    endfunction : txf_read

    function automatic logic txf_mapped(input logic [7:0] addr);
        return addr == `TXF_ADDR_PRIMARY || addr == `TXF_ADDR_ALT
            || addr == `TXF_ADDR_SECOND || addr == `TXF_ADDR_CTRL
            || addr == `TXF_ADDR_STAT;
    endfunction : txf_mapped

    // Link is up only while both its reset and its stop are released
    assign link_up = core_ff.rst_s2 & core_ff.stop_s2;
    assign up_fall = core_ff.up_prev & ~link_up;
    // Hold window runs once; a second assertion inside it is absorbed
    assign apply = (up_fall && !core_ff.gen1 && !core_ff.holding)
        || (core_ff.holding && core_ff.hold_cnt == 9'h000);
    // Unsupported codes fall back to the mandatory 200 MHz
    assign apply_code = RATE_SUPPORT[core_ff.sel] ? core_ff.sel : `TXF_SEL_RESET;
    assign aw_ready = !core_ff.aw_got && !core_ff.bvalid;
    assign w_ready = !core_ff.w_got && !core_ff.bvalid;
    assign ar_ready = !core_ff.rvalid;

    always_comb
    begin
        nxt_core = core_ff;
        nxt_core.rst_s1 = LINK_RESET_N;
        nxt_core.rst_s2 = core_ff.rst_s1;
        nxt_core.stop_s1 = LINK_STOP_DISCONNECT_N;
        nxt_core.stop_s2 = core_ff.stop_s1;
        nxt_core.ac_s1 = AC_COUPLED;
        nxt_core.ac_s2 = core_ff.ac_s1;
        nxt_core.ack_s1 = link_ff.ack_tgl;
        nxt_core.ack_s2 = core_ff.ack_s1;
        nxt_core.up_prev = link_up;

        if (S_AXI_AWVALID && aw_ready)
        begin
            nxt_core.aw_got = 1'b1;
            nxt_core.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && w_ready)
        begin
            nxt_core.w_got = 1'b1;
            nxt_core.w_data = S_AXI_WDATA[7:0];
            nxt_core.w_lane0 = S_AXI_WSTRB[0];
        end
        if (core_ff.aw_got && core_ff.w_got)
        begin
            nxt_core.aw_got = 1'b0;
            nxt_core.w_got = 1'b0;
            nxt_core.bvalid = 1'b1;
            nxt_core.bresp = txf_mapped(core_ff.aw_addr) ? `TXF_RESP_OKAY : `TXF_RESP_SLVERR;
            if (core_ff.w_lane0)
            begin
                if (core_ff.aw_addr == `TXF_ADDR_PRIMARY || core_ff.aw_addr == `TXF_ADDR_ALT)
                begin
                    nxt_core.sel = core_ff.w_data[`TXF_SEL_MSB:`TXF_SEL_LSB];
                end
                else if (core_ff.aw_addr == `TXF_ADDR_CTRL)
                begin
                    nxt_core.mode = txf_mode_e'(
                        core_ff.w_data[`TXF_CTRL_MODE_MSB:`TXF_CTRL_MODE_LSB]);
                    nxt_core.gen1 = core_ff.w_data[`TXF_CTRL_GEN1];
                end
                // Second link copy is reserved: the write is accepted and dropped
            end
        end
        if (core_ff.bvalid && S_AXI_BREADY)
        begin
            nxt_core.bvalid = 1'b0;
        end
        if (core_ff.rvalid && S_AXI_RREADY)
        begin
            nxt_core.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && ar_ready)
        begin
            nxt_core.rvalid = 1'b1;
            nxt_core.rdata = txf_read(core_ff, S_AXI_ARADDR);
            nxt_core.rresp = txf_mapped(S_AXI_ARADDR) ? `TXF_RESP_OKAY : `TXF_RESP_SLVERR;
        end

        // Only the link's own reset and stop pins open the window
        if (up_fall && core_ff.gen1 && !core_ff.holding)
        begin
            nxt_core.holding = 1'b1;
            nxt_core.hold_cnt = HOLD_LAST;
        end
        else if (core_ff.holding)
        begin
            nxt_core.hold_cnt = core_ff.hold_cnt - 9'h001;
            if (core_ff.hold_cnt == 9'h000)
            begin
                nxt_core.holding = 1'b0;
            end
        end
        if (apply)
        begin
            nxt_core.in_use = apply_code;
        end
        // Strap is read once, after it has settled through its synchroniser
        if (!core_ff.strap_done)
        begin
            nxt_core.strap_done = 1'b1;
            if (core_ff.ac_s2)
            begin
                nxt_core.in_use = `TXF_AC_DEFAULT;
            end
        end

        // Word stays frozen until the link side has echoed the toggle
        if (core_ff.ack_s2 == core_ff.req_tgl
            && core_ff.xfer_word != {core_ff.mode, core_ff.in_use})
        begin
            nxt_core.xfer_word = {core_ff.mode, core_ff.in_use};
            nxt_core.req_tgl = ~core_ff.req_tgl;
        end

        if (RESET)
        begin
            nxt_core = '0;
            nxt_core.sel = `TXF_SEL_RESET;
            nxt_core.mode = TXF_SYNC;
            // Strap synchroniser keeps running, else the first edge after release misses it
            nxt_core.ac_s1 = AC_COUPLED;
            nxt_core.ac_s2 = core_ff.ac_s1;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        core_ff <= nxt_core;
    end

    always_comb
    begin
        nxt_link = link_ff;
        nxt_link.rst_s1 = RESET;
        nxt_link.rst_s2 = link_ff.rst_s1;
        nxt_link.req_s1 = core_ff.req_tgl;
        nxt_link.req_s2 = link_ff.req_s1;
        if (link_ff.req_s2 != link_ff.req_seen)
        begin
            nxt_link.req_seen = link_ff.req_s2;
            nxt_link.ack_tgl = link_ff.req_s2;
            nxt_link.word = core_ff.xfer_word;
            nxt_link.mhz = txf_mhz(core_ff.xfer_word[3:0]);
        end
        if (link_ff.rst_s2)
        begin
            nxt_link.req_seen = 1'b0;
            nxt_link.ack_tgl = 1'b0;
            nxt_link.word = {TXF_SYNC, `TXF_SEL_RESET};
            nxt_link.mhz = txf_mhz(`TXF_SEL_RESET);
        end
    end

    always_ff @(posedge LINK_CLOCK)
    begin
        link_ff <= nxt_link;
    end

    assign S_AXI_AWREADY = aw_ready;
    assign S_AXI_WREADY = w_ready;
    assign S_AXI_ARREADY = ar_ready;
    assign S_AXI_BVALID = core_ff.bvalid;
    assign S_AXI_BRESP = core_ff.bresp;
    assign S_AXI_RVALID = core_ff.rvalid;
    assign S_AXI_RRESP = core_ff.rresp;
    assign S_AXI_RDATA = {24'h00_0000, core_ff.rdata};
    assign TX_RATE_CODE = link_ff.word[3:0];
    assign TX_CLOCK_MHZ = link_ff.mhz;
    assign DATA_RATE_MHZ = {link_ff.mhz, 1'b0};
    assign RATE_IS_LIMIT = link_ff.word[5:4] != TXF_SYNC;
    assign RX_AT_TX_RATE = link_ff.word[5:4] == TXF_SYNC;
    assign VENDOR_RATE = link_ff.word[3:0] == 4'hf;

    a_sel_reset_zero: assert property (@(posedge CLOCK)
        RESET |=> core_ff.sel == 4'h0)
        else $error("select not cleared by reset");

    a_write_sel_lands: assert property (@(posedge CLOCK) disable iff (RESET)
        (core_ff.aw_got && core_ff.w_got && core_ff.w_lane0
        && core_ff.aw_addr == `TXF_ADDR_PRIMARY) |=> core_ff.sel == $past(core_ff.w_data[3:0]))
        else $error("written select did not land");

    a_strobe_guard: assert property (@(posedge CLOCK) disable iff (RESET)
        (core_ff.aw_got && core_ff.w_got && !core_ff.w_lane0) |=> $stable(core_ff.sel))
        else $error("select written without byte strobe");

    a_write_answer: assert property (@(posedge CLOCK) disable iff (RESET)
        (core_ff.aw_got && core_ff.w_got) |=> S_AXI_BVALID && !S_AXI_AWREADY)
        else $error("write not answered");

    a_read_answer: assert property (@(posedge CLOCK) disable iff (RESET)
        (S_AXI_ARVALID && ar_ready) |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h00_0000)
        else $error("read not answered");

    a_sel_read_back: assert property (@(posedge CLOCK) disable iff (RESET)
        (S_AXI_ARVALID && ar_ready && S_AXI_ARADDR == `TXF_ADDR_ALT)
        |=> S_AXI_RDATA[3:0] == $past(core_ff.sel))
        else $error("alias read differs from select");

    a_second_reserved: assert property (@(posedge CLOCK) disable iff (RESET)
        (S_AXI_ARVALID && ar_ready && S_AXI_ARADDR == 8'h44)
        |=> S_AXI_RDATA == 32'h0000_0000)
        else $error("second link copy not reserved");

    a_second_dropped: assert property (@(posedge CLOCK) disable iff (RESET)
        (core_ff.aw_got && core_ff.w_got && core_ff.aw_addr == `TXF_ADDR_SECOND)
        |=> $stable(core_ff.sel) && $stable(core_ff.mode))
        else $error("write to second link copy took effect");

    a_write_not_applied: assert property (@(posedge CLOCK) disable iff (RESET)
        (core_ff.strap_done && !apply) |=> $stable(core_ff.in_use))
        else $error("in-use rate moved without a link event");

    a_apply_loads_sel: assert property (@(posedge CLOCK) disable iff (RESET)
        (apply && core_ff.strap_done) |=> core_ff.in_use == $past(apply_code))
        else $error("in-use rate not loaded from select");

    a_status_in_use: assert property (@(posedge CLOCK) disable iff (RESET)
        (S_AXI_ARVALID && ar_ready && S_AXI_ARADDR == `TXF_ADDR_STAT)
        |=> S_AXI_RDATA[3:0] == $past(core_ff.in_use))
        else $error("status does not show in-use rate");

    // Window length is the 2 us hold at the register clock
    a_hold_two_us: assert property (@(posedge CLOCK) disable iff (RESET)
        (up_fall && core_ff.gen1 && !core_ff.holding)
        |-> ##250 (apply && core_ff.holding))
        else $error("hold window not 250 cycles");

    a_hold_keeps_rate: assert property (@(posedge CLOCK) disable iff (RESET)
        (core_ff.holding && core_ff.hold_cnt != 9'h000) |=> $stable(core_ff.in_use))
        else $error("rate changed inside hold window");

    a_no_hold_apply: assert property (@(posedge CLOCK) disable iff (RESET)
        (up_fall && !core_ff.gen1 && !core_ff.holding)
        |=> core_ff.in_use == ($past(core_ff.sel) == 4'hf ? 4'h0 : $past(core_ff.sel)))
        else $error("link event did not apply rate");

    a_rate_supported: assert property (@(posedge CLOCK) disable iff (RESET)
        core_ff.strap_done |-> RATE_SUPPORT[core_ff.in_use])
        else $error("unsupported rate in use");

    a_ac_default: assert property (@(posedge CLOCK) disable iff (RESET)
        (!core_ff.strap_done && core_ff.ac_s2) |=> core_ff.in_use == 4'h7)
        else $error("ac-coupled default not 1.2 GHz");

    // A word that moves mid-handshake would be captured torn on the link side
    a_xfer_frozen: assert property (@(posedge CLOCK) disable iff (RESET)
        (core_ff.ack_s2 != core_ff.req_tgl) |=> $stable(core_ff.xfer_word))
        else $error("crossing word moved before echo");

    a_link_reset_rate: assert property (@(posedge LINK_CLOCK)
        link_ff.rst_s2 |=> TX_RATE_CODE == 4'h0 && TX_CLOCK_MHZ == 12'h0c8 && RX_AT_TX_RATE)
        else $error("link reset rate not 200 MHz synchronous");

    a_link_word_held: assert property (@(posedge LINK_CLOCK) disable iff (link_ff.rst_s2)
        (link_ff.req_s2 == link_ff.req_seen) |=> $stable(link_ff.word))
        else $error("link rate moved without a request");

    a_decode_800: assert property (@(posedge LINK_CLOCK) disable iff (link_ff.rst_s2)
        (link_ff.word[3:0] == 4'h5) |-> TX_CLOCK_MHZ == 12'h320)
        else $error("code 5 not 800 MHz");

    a_mode_flags: assert property (@(posedge LINK_CLOCK) disable iff (link_ff.rst_s2)
        RX_AT_TX_RATE |-> !RATE_IS_LIMIT && DATA_RATE_MHZ == 13'(TX_CLOCK_MHZ * 2))
        else $error("sync mode flags wrong");
endmodule : txf_rate_select

//--- verification/txf_peer_model.sv
// Purpose: Far-end link peer that drives link clock, link reset and stop pins
// Assumes: Pins rest high; each pulse lasts four register clocks
// Notes: Link clock runs free, as the block expects
module txf_peer_model
(
    input wire logic clk,
    input wire logic [3:0] tx_rate_code,
    output logic link_clk,
    output logic link_reset_n,
    output logic link_stop_n,
    output logic rate_match
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] peer_code;

    initial
    begin
        link_reset_n = 1'b1;
        link_stop_n = 1'b1;
        peer_code = 4'h0;
        link_clk = 1'b0;
        // Odd offset keeps the two clocks apart in phase
        #3;
        forever #32 link_clk = ~link_clk;
    end

    // Differing ends would not finish link training
    assign rate_match = (tx_rate_code === peer_code);

    task automatic program_code(input logic [3:0] code);
        peer_code = code;
    endtask : program_code

    // Only called once the register writes have completed
    // Stop pulses take stop skew select as already cleared by software
    task automatic pulse(input logic use_stop);
        @(posedge clk);
        if (use_stop)
            link_stop_n <= 1'b0;
        else
            link_reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        link_stop_n <= 1'b1;
        link_reset_n <= 1'b1;
    endtask : pulse
endmodule : txf_peer_model

//--- verification/tb.sv
// Purpose: Self-checking bench for the transmit clock rate select block
// Assumes: AXI4-Lite master tasks; peer model drives the link pins
// Notes: Link outputs are sampled well after the crossing settles
`include "txf_consts.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 20000;
    logic clk, rst, ac, link_clk, lrst_n, lstop_n, match;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, code;
    logic [1:0] bresp, rresp;
    logic [11:0] mhz;
    logic [12:0] drate;
    logic limit, rx_at, vendor;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    txf_rate_select dut (.CLOCK(clk), .RESET(rst), .LINK_CLOCK(link_clk),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1), .LINK_RESET_N(lrst_n),
        .LINK_STOP_DISCONNECT_N(lstop_n), .AC_COUPLED(ac), .TX_RATE_CODE(code),
        .TX_CLOCK_MHZ(mhz), .DATA_RATE_MHZ(drate), .RATE_IS_LIMIT(limit),
        .RX_AT_TX_RATE(rx_at), .VENDOR_RATE(vendor));

    txf_peer_model peer (.clk(clk), .tx_rate_code(code), .link_clk(link_clk),
        .link_reset_n(lrst_n), .link_stop_n(lstop_n), .rate_match(match));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Handshakes are judged at the falling edge, acted on at the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        logic aw_go, w_go, b_go;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        b_go = 1'b0;
        while (!b_go)
        begin
            @(negedge clk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            b_go = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_go)
                awvalid <= 1'b0;
            if (w_go)
                wvalid <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_go, r_go;
        araddr <= a;
        arvalid <= 1'b1;
        r_go = 1'b0;
        while (!r_go)
        begin
            @(negedge clk);
            ar_go = arvalid && arready;
            r_go = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_go)
                arvalid <= 1'b0;
        end
    endtask : rd

    // 200..600 in 100 steps, 800, 1000, then 1200 up in 200 steps
    function automatic logic [11:0] mhz_of(input logic [3:0] c);
        if (c < 4'h5)
            return 12'h0c8 + 12'h064 * c;
        if (c < 4'h7)
            return 12'h320 + 12'h0c8 * (c - 4'h5);
        return 12'h4b0 + 12'h0c8 * (c - 4'h7);
    endfunction : mhz_of

    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] want, prev;
        rst = 1'b1;
        ac = 1'b0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        prev = 4'h0;
        // Longer than one link clock (eight cycles) so the link side also sees reset
        repeat (24) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`TXF_ADDR_PRIMARY, d, r);
        chk(d, 32'h0);
        chk(code, 4'h0);
        chk(mhz, 12'h0c8);
        chk(drate, 13'h0190);
        chk({rx_at, limit}, 2'h2);
        rd(8'hf0, d, r);
        chk({r, d}, {`TXF_RESP_SLVERR, 32'h0});
        wr(8'hf0, 32'h5, 4'hf, r);
        chk(r, `TXF_RESP_SLVERR);
        wr(`TXF_ADDR_SECOND, 32'h3, 4'hf, r);
        rd(`TXF_ADDR_SECOND, d, r);
        chk(d, 32'h0);
        // Block has no link management, retry, scrambling or retrain controls
        for (int c = 0; c < 16; c++)
        begin
            want = (c == 15) ? 4'h0 : 4'(c);
            wr(`TXF_ADDR_CTRL, 32'(c % 4), 4'hf, r);
            wr(`TXF_ADDR_PRIMARY, 32'(c), 4'hf, r);
            chk(r, `TXF_RESP_OKAY);
            rd(`TXF_ADDR_ALT, d, r);
            chk(d, 32'(c));
            repeat (40) @(posedge clk);
            chk(code, prev);
            peer.program_code(want);
            peer.pulse(c[0]);
            repeat (60) @(posedge clk);
            chk(code, want);
            chk(mhz, mhz_of(want));
            chk(drate, {mhz_of(want), 1'b0});
            chk(limit, c % 4 != 0);
            chk(rx_at, c % 4 == 0);
            chk({vendor, match}, 2'h1);
            rd(`TXF_ADDR_STAT, d, r);
            chk(d[3:0], want);
            prev = want;
        end
        wr(`TXF_ADDR_CTRL, 32'h4, 4'hf, r);
        wr(`TXF_ADDR_PRIMARY, 32'h2, 4'hf, r);
        peer.program_code(4'h2);
        peer.pulse(1'b0);
        repeat (100) @(posedge clk);
        rd(`TXF_ADDR_STAT, d, r);
        chk(d & 32'h1f, 32'h10);
        chk(code, 4'h0);
        repeat (250) @(posedge clk);
        rd(`TXF_ADDR_STAT, d, r);
        chk(d & 32'h1f, 32'h2);
        wr(`TXF_ADDR_PRIMARY, 32'h9, 4'he, r);
        rd(`TXF_ADDR_PRIMARY, d, r);
        chk({r, d}, {`TXF_RESP_OKAY, 32'h2});
        ac <= 1'b1;
        rst <= 1'b1;
        repeat (24) @(posedge clk);
        rst <= 1'b0;
        repeat (40) @(posedge clk);
        chk(code, 4'h7);
        chk(mhz, 12'h4b0);
        rd(`TXF_ADDR_PRIMARY, d, r);
        chk(d, 32'h0);
        rd(`TXF_ADDR_STAT, d, r);
        chk(d & 32'h4f, 32'h47);
        report_and_stop();
    end
endmodule : tb
